// File: hw/alu_cfg.svh
/*
  constants for the subtract / carry / shift alu: opcodes, lengths, cycle counts, flag bits.
  assumes inclusion by bare name from any design file.
*/
// Functional notes
// - dst minus src minus borrow; borrow flag updated
// - zero, negative, wrap from result; minus flag set
// - nibble borrow clear on bit3 carry, else set
// - decode opcodes 32..36 with lengths, cycles
// - opcode df sets borrow flag only
// - shift right, bit7 kept and copied
// - borrow flag takes old bit 0
// - zero and negative from shift result
// - shift clears wrap, keeps minus, nibble
// - opcodes d0, d1 shift; two bytes four cycles
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH
`define OPC_SWB_RR    8'h32
`define OPC_SWB_RIR   8'h33
`define OPC_SWB_GG    8'h34
`define OPC_SWB_GI    8'h35
`define OPC_SWB_GL    8'h36
`define OPC_SET_BO    8'hdf
`define OPC_ASR_G     8'hd0
`define OPC_ASR_I     8'hd1
`define FLG_BO        7
`define FLG_ZERO      6
`define FLG_NEG       5
`define FLG_WRAP      4
`define FLG_MINUS     3
`define FLG_NIB       2
`define FLAGS_RST     8'h00
`define CYC_SHORT     4'h4
`define CYC_LONG      4'h6
`define LEN_ONE       2'h1
`define LEN_TWO       2'h2
`define LEN_THREE     2'h3
`endif

// File: hw/alu_pkg.sv
/*
  types for the subtract / carry / shift alu.
  assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package alu_pkg;
  typedef enum logic [1:0] {op_none_t_v, op_subb, op_setbo, op_asr} alu_op_t;
  typedef enum logic [2:0] {am_none, am_work, am_work_ind, am_reg, am_reg_ind, am_lit}
    addr_mode_t;
endpackage
`default_nettype wire

// File: hw/op_decode.sv
/*
  opcode decoder: operation, operand modes, length and cycle count.
  assumes the opcode byte is held steady for as long as its decode is used.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alu_cfg.svh"
module op_decode
(
  input  wire logic [7:0]          opcode,
  output alu_pkg::alu_op_t         op,
  output alu_pkg::addr_mode_t      dst_mode,
  output alu_pkg::addr_mode_t      src_mode,
  output logic [1:0]               length,
  output logic [3:0]               cycles,
  output logic                     src_first
);
  always_comb
  begin
    op        = alu_pkg::op_none_t_v;
    dst_mode  = alu_pkg::am_none;
    src_mode  = alu_pkg::am_none;
    length    = 2'h0;
    cycles    = 4'h0;
    src_first = 1'b0;
    case (opcode)
      `OPC_SWB_RR:
      begin
        op       = alu_pkg::op_subb;
        dst_mode = alu_pkg::am_work;
        src_mode = alu_pkg::am_work;
        length   = `LEN_TWO;
        cycles   = `CYC_SHORT;
      end
      `OPC_SWB_RIR:
      begin
        op       = alu_pkg::op_subb;
        dst_mode = alu_pkg::am_work;
        src_mode = alu_pkg::am_work_ind;
        length   = `LEN_TWO;
        cycles   = `CYC_LONG;
      end
      `OPC_SWB_GG:
      begin
        op        = alu_pkg::op_subb;
        dst_mode  = alu_pkg::am_reg;
        src_mode  = alu_pkg::am_reg;
        length    = `LEN_THREE;
        cycles    = `CYC_LONG;
        src_first = 1'b1;
      end
      `OPC_SWB_GI:
      begin
        op        = alu_pkg::op_subb;
        dst_mode  = alu_pkg::am_reg;
        src_mode  = alu_pkg::am_reg_ind;
        length    = `LEN_THREE;
        cycles    = `CYC_LONG;
        src_first = 1'b1;
      end
      `OPC_SWB_GL:
      begin
        op       = alu_pkg::op_subb;
        dst_mode = alu_pkg::am_reg;
        src_mode = alu_pkg::am_lit;
        length   = `LEN_THREE;
        cycles   = `CYC_LONG;
      end
      `OPC_SET_BO:
      begin
        op     = alu_pkg::op_setbo;
        length = `LEN_ONE;
        cycles = `CYC_SHORT;
      end
      `OPC_ASR_G:
      begin
        op       = alu_pkg::op_asr;
        dst_mode = alu_pkg::am_reg;
        length   = `LEN_TWO;
        cycles   = `CYC_SHORT;
      end
      `OPC_ASR_I:
      begin
        op       = alu_pkg::op_asr;
        dst_mode = alu_pkg::am_reg_ind;
        length   = `LEN_TWO;
        cycles   = `CYC_SHORT;
      end
      default:
      begin
        op = alu_pkg::op_none_t_v;
      end
    endcase
  end
endmodule
`default_nettype wire

// File: hw/subtract_carry_shift_alu.sv
/*
  execution slice for subtract-with-borrow, force-borrow and arithmetic shift right.
  assumes the decoder stage fetches operands; exec_valid is a one-cycle strobe with
  opcode, dst_val and src_val stable in that cycle. result and flags appear the next cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alu_cfg.svh"
module subtract_carry_shift_alu
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        exec_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  dst_val,
  input  wire logic [7:0]  src_val,
  input  wire logic        flags_load,
  input  wire logic [7:0]  flags_in,
  output logic             done,
  output logic             illegal,
  output logic             result_we,
  output logic [7:0]       result,
  output logic [7:0]       flags,
  output alu_pkg::addr_mode_t dst_mode,
  output alu_pkg::addr_mode_t src_mode,
  output logic [1:0]       length,
  output logic [3:0]       cycles,
  output logic             src_first
);
  alu_pkg::alu_op_t op;
  logic [7:0] flags_q, flags_d, result_q, result_d;
  logic       done_q, done_d, ill_q, ill_d, we_q, we_d;
  logic [8:0] diff;
  logic [4:0] low;

  op_decode u_dec
  (
    .opcode    (opcode),
    .op        (op),
    .dst_mode  (dst_mode),
    .src_mode  (src_mode),
    .length    (length),
    .cycles    (cycles),
    .src_first (src_first)
  );

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // borrow is tracked in a ninth bit; nibble carry via complement addition
  always_comb
  begin
    flags_d  = flags_q;
    result_d = result_q;
    done_d   = 1'b0;
    ill_d    = 1'b0;
    we_d     = 1'b0;
    diff = {1'b0, dst_val} - {1'b0, src_val} - {8'h00, flags_q[`FLG_BO]};
    low  = {1'b0, dst_val[3:0]} + {1'b0, ~src_val[3:0]} + {4'h0, ~flags_q[`FLG_BO]};
    // flags_in lands first so an execute in the same cycle overwrites its own bits
    if (flags_load)
      flags_d = flags_in;
    if (exec_valid)
    begin
      done_d = 1'b1;
      case (op)
        alu_pkg::op_subb:
        begin
          result_d = diff[7:0];
          we_d = 1'b1;
          flags_d[`FLG_BO]    = diff[8];
          flags_d[`FLG_ZERO]  = is_zero(diff[7:0]);
          flags_d[`FLG_NEG]   = diff[7];
          flags_d[`FLG_WRAP]  = (dst_val[7] ^ src_val[7]) & (diff[7] == src_val[7]);
          flags_d[`FLG_MINUS] = 1'b1;
          flags_d[`FLG_NIB]   = ~low[4];
        end
        alu_pkg::op_setbo:
          flags_d[`FLG_BO] = 1'b1;
        alu_pkg::op_asr:
        begin
          result_d = {dst_val[7], dst_val[7:1]};
          we_d = 1'b1;
          flags_d[`FLG_BO]   = dst_val[0];
          flags_d[`FLG_ZERO] = is_zero({dst_val[7], dst_val[7:1]});
          flags_d[`FLG_NEG]  = dst_val[7];
          flags_d[`FLG_WRAP] = 1'b0;
        end
        default:
        begin
          // a refused opcode only pulses illegal; result and flags keep
          ill_d  = 1'b1;
          done_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_q  <= `FLAGS_RST;
      result_q <= 8'h00;
      done_q   <= 1'b0;
      ill_q    <= 1'b0;
      we_q     <= 1'b0;
    end
    else
    begin
      flags_q  <= flags_d;
      result_q <= result_d;
      done_q   <= done_d;
      ill_q    <= ill_d;
      we_q     <= we_d;
    end
  end

  assign flags     = flags_q;
  assign result    = result_q;
  assign done      = done_q;
  assign illegal   = ill_q;
  assign result_we = we_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks use their own arithmetic so that a slip in diff or low shows up
  property p_subb_result;
    @(posedge clk) disable iff (!rst_n)
    (exec_valid && opcode == `OPC_SWB_RR && !flags_load) |=>
      result == 8'($past(dst_val) - $past(src_val) - {7'h00, $past(flags_q[`FLG_BO])});
  endproperty
  a_subb_result: assert property (p_subb_result) else $error("difference wrong");
  sequence s_subb;
    exec_valid && op == alu_pkg::op_subb;
  endsequence
  property p_subb_borrow;
    @(posedge clk) disable iff (!rst_n)
    s_subb |=> result_we && done && !illegal &&
      flags[`FLG_BO] == ({1'b0, $past(dst_val)} <
                         {1'b0, $past(src_val)} + {8'h00, $past(flags_q[`FLG_BO])});
  endproperty
  a_subb_borrow: assert property (p_subb_borrow) else $error("borrow flag wrong");
  property p_subb_znv;
    @(posedge clk) disable iff (!rst_n)
    s_subb |=> flags[`FLG_ZERO] == (result == 8'h00) && flags[`FLG_NEG] == result[7] &&
      flags[`FLG_WRAP] == ($past(dst_val[7]) != $past(src_val[7]) &&
                           result[7] == $past(src_val[7]));
  endproperty
  a_subb_znv: assert property (p_subb_znv) else $error("z, n or wrap flag wrong");
  property p_subb_minus;
    @(posedge clk) disable iff (!rst_n)
    (exec_valid && opcode == `OPC_SWB_GL) |=> flags[`FLG_MINUS] && result_we;
  endproperty
  a_subb_minus: assert property (p_subb_minus) else $error("minus flag not set");
  property p_subb_nib;
    @(posedge clk) disable iff (!rst_n)
    s_subb |=> flags[`FLG_NIB] ==
      ({1'b0, $past(dst_val[3:0])} <
       {1'b0, $past(src_val[3:0])} + {4'h0, $past(flags_q[`FLG_BO])});
  endproperty
  a_subb_nib: assert property (p_subb_nib) else $error("nibble borrow wrong");
  property p_len;
    @(posedge clk) disable iff (!rst_n)
    (opcode == `OPC_SWB_GI) |-> length == `LEN_THREE && cycles == `CYC_LONG && src_first;
  endproperty
  a_len: assert property (p_len) else $error("decode of 35 wrong");
  property p_refuse;
    @(posedge clk) disable iff (!rst_n)
    (exec_valid && op == alu_pkg::op_none_t_v && !flags_load) |=>
      illegal && !done && !result_we && $stable(result) && $stable(flags);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused opcode changed state");
  property p_load;
    @(posedge clk) disable iff (!rst_n)
    (flags_load && !exec_valid) |=> flags == $past(flags_in) && !done && !result_we;
  endproperty
  a_load: assert property (p_load) else $error("flag load wrong");
  // pulses must never appear on their own, or the register file would take junk
  property p_quiet;
    @(posedge clk) disable iff (!rst_n)
    !exec_valid |=> !done && !illegal && !result_we;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pulse without an execute");
  property p_setbo;
    @(posedge clk) disable iff (!rst_n)
    (exec_valid && opcode == `OPC_SET_BO && !flags_load) |=>
      flags == ($past(flags) | 8'h80) && !result_we;
  endproperty
  a_setbo: assert property (p_setbo) else $error("set borrow wrong");
  sequence s_asr;
    exec_valid && opcode == `OPC_ASR_G && !flags_load;
  endsequence
  property p_asr;
    @(posedge clk) disable iff (!rst_n)
    s_asr |=> result == {$past(dst_val[7]), $past(dst_val[7:1])}
      && flags[`FLG_BO] == $past(dst_val[0]);
  endproperty
  a_asr: assert property (p_asr) else $error("shift result wrong");
  property p_asr_flags;
    @(posedge clk) disable iff (!rst_n)
    s_asr |=> flags[`FLG_ZERO] == (result == 8'h00) && flags[`FLG_NEG] == result[7];
  endproperty
  a_asr_flags: assert property (p_asr_flags) else $error("shift z/n wrong");
  property p_asr_keep;
    @(posedge clk) disable iff (!rst_n)
    s_asr |=> !flags[`FLG_WRAP] && flags[3:2] == $past(flags[3:2]);
  endproperty
  a_asr_keep: assert property (p_asr_keep) else $error("shift v/d/h wrong");
  property p_asr_len;
    @(posedge clk) disable iff (!rst_n)
    (opcode == `OPC_ASR_I) |-> length == `LEN_TWO && cycles == `CYC_SHORT;
  endproperty
  a_asr_len: assert property (p_asr_len) else $error("decode of d1 wrong");
  property p_asr_ind;
    @(posedge clk) disable iff (!rst_n)
    (exec_valid && opcode == `OPC_ASR_I && !flags_load) |=> result_we && done &&
      result == {$past(dst_val[7]), $past(dst_val[7:1])} &&
      flags[`FLG_BO] == $past(dst_val[0]);
  endproperty
  a_asr_ind: assert property (p_asr_ind) else $error("indirect shift wrong");
endmodule
`default_nettype wire

// File: sim/testbench.sv
/*
  self-checking bench for the subtract / carry / shift alu: operations driven
  back to back, flags tracked in a bench-side copy.
  assumes the opcode and flag layout of alu_cfg.svh and single-cycle execution.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alu_cfg.svh"
module testbench;
  logic                clk, rst_n, exec_valid, flags_load, done, illegal, result_we, src_first;
  logic [7:0]          opcode, dst_val, src_val, flags_in, result, flags, ef, er;
  logic [1:0]          length;
  logic [3:0]          cycles;
  alu_pkg::addr_mode_t dst_mode, src_mode;
  int                  miscompares, n_tests;

  subtract_carry_shift_alu dut (.clk(clk), .rst_n(rst_n), .exec_valid(exec_valid),
    .opcode(opcode), .dst_val(dst_val), .src_val(src_val), .flags_load(flags_load),
    .flags_in(flags_in), .done(done), .illegal(illegal), .result_we(result_we),
    .result(result), .flags(flags), .dst_mode(dst_mode), .src_mode(src_mode),
    .length(length), .cycles(cycles), .src_first(src_first));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic ld(input logic [7:0] v);
    exec_valid = 1'b0;
    flags_in = v;
    flags_load = 1'b1;
    @(posedge clk);
    #1;
    flags_load = 1'b0;
    ef = v;
    chk(flags, ef);
  endtask

  // dec packs {length, cycles, dst_mode, src_mode, src_first}
  task automatic op(input logic [7:0] opc, d, s, input logic [12:0] dec);
    logic [8:0]  w;
    logic        leg;
    logic [18:0] exp_o;
    opcode = opc;
    dst_val = d;
    src_val = s;
    exec_valid = 1'b1;
    leg = 1'b1;
    if (opc inside {[`OPC_SWB_RR:`OPC_SWB_GL]})
    begin
      w = {1'b0, d} - s - ef[`FLG_BO];
      er = w[7:0];
      ef[7:2] = {w[8], er == 8'h00, er[7], (d[7] ^ s[7]) & ~(er[7] ^ s[7]), 1'b1,
                 {1'b0, d[3:0]} < s[3:0] + ef[`FLG_BO]};
    end
    else if (opc == `OPC_SET_BO)
      ef[`FLG_BO] = 1'b1;
    else if (opc == `OPC_ASR_G || opc == `OPC_ASR_I)
    begin
      er = {d[7], d[7:1]};
      ef[7:4] = {d[0], er == 8'h00, er[7], 1'b0};
    end
    else
      leg = 1'b0;
    exp_o = {leg, ~leg, leg & (opc != `OPC_SET_BO), er, ef};
    #1;
    chk({length, cycles, dst_mode, src_mode, src_first}, dec);
    @(posedge clk);
    #1;
    chk({done, illegal, result_we, result, flags}, exp_o);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the whole sequence needs well under 100 cycles
  initial
  begin
    #5us;
    miscompares++;
    close_out();
  end

  initial
  begin
    miscompares = 0;
    n_tests = 0;
    er = 8'h00;
    ef = `FLAGS_RST;
    rst_n = 1'b0;
    exec_valid = 1'b0;
    flags_load = 1'b0;
    opcode = 8'h00;
    dst_val = 8'h00;
    src_val = 8'h00;
    flags_in = 8'h00;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk({done, illegal, result_we, result, flags}, 24'h000000);
    ld(8'h80);
    op(8'h32, 8'h10, 8'h03, 13'h1212);
    op(8'h33, 8'h20, 8'h0a, 13'h1314);
    op(8'h34, 8'h03, 8'h20, 13'h1b37);
    op(8'h35, 8'h80, 8'h01, 13'h1b39);
    op(8'h35, 8'h0f, 8'h01, 13'h1b39);
    op(8'h36, 8'h01, 8'h8a, 13'h1b3a);
    op(8'h36, 8'h76, 8'h75, 13'h1b3a);
    ld(8'h3c);
    op(8'hdf, 8'h55, 8'h00, 13'h0a00);
    op(8'hdf, 8'h00, 8'h00, 13'h0a00);
    op(8'hd0, 8'h9a, 8'h00, 13'h1230);
    op(8'hd1, 8'h01, 8'h00, 13'h1240);
    op(8'hd0, 8'hbc, 8'h00, 13'h1230);
    op(8'h00, 8'h12, 8'h34, 13'h0000);
    op(8'h32, 8'h00, 8'h00, 13'h1212);
    close_out();
  end
endmodule
`default_nettype wire
